// ===== include/hmp_pkg.sv
// package: register map, fields, reset values and timing of the mode/power block
package hmp_pkg;
	// ****************
	// register offsets
	// ****************
	localparam logic [7:0] HMP_ADDR_FAULT_STATUS = 8'h00;
	localparam logic [7:0] HMP_ADDR_MODE_POWER = 8'h01;
	localparam logic [7:0] HMP_ADDR_SEQ_FIRST = 8'h04;
	localparam logic [7:0] HMP_ADDR_SEQ_LAST = 8'h0b;
	localparam logic [7:0] HMP_ADDR_FIRE_CONTROL = 8'h0c;
	localparam logic [7:0] HMP_ADDR_SUPPLY_LEVEL = 8'h21;
	// ****************
	// field positions
	// ****************
	localparam int HMP_BIT_SHORT_FLAG = 0;
	localparam int HMP_BIT_OVER_TEMP = 1;
	localparam int HMP_BIT_PWM_SELECT = 3;
	localparam int HMP_BIT_STANDBY = 6;
	localparam int HMP_BIT_SOFT_RESET = 7;
	localparam int HMP_BIT_GO = 0;
	localparam int HMP_SEQ_DEPTH = 8;
	// ****************
	// reset values
	// ****************
	localparam logic [7:0] HMP_RST_MODE_POWER = 8'h40;
	localparam logic [7:0] HMP_RST_SEQ = 8'h00;
	localparam logic [7:0] HMP_RST_SUPPLY = 8'h00;
	// ****************
	// modes
	// ****************
	localparam logic [2:0] HMP_MODE_INTERNAL = 3'h0;
	localparam logic [2:0] HMP_MODE_EDGE = 3'h1;
	localparam logic [2:0] HMP_MODE_LEVEL = 3'h2;
	localparam logic [2:0] HMP_MODE_ANALOG_PWM = 3'h3;
	localparam logic [2:0] HMP_MODE_AUDIO_VIBE = 3'h4;
	localparam logic [2:0] HMP_MODE_REALTIME = 3'h5;
	localparam logic [2:0] HMP_MODE_DIAG = 3'h6;
	localparam logic [2:0] HMP_MODE_CALIB = 3'h7;
	// ****************
	// timing
	// ****************
	localparam int HMP_CLK_PERIOD_NS = 50;
	localparam int HMP_WDT_TIME_NS = 4330000;
	localparam int HMP_WDT_CYCLES = HMP_WDT_TIME_NS / HMP_CLK_PERIOD_NS;
	localparam int HMP_RECHECK_TIME_NS = 100000;
	localparam int HMP_RECHECK_CYCLES = HMP_RECHECK_TIME_NS / HMP_CLK_PERIOD_NS;
	localparam int HMP_CNT_W = 17;
	typedef enum {HMP_IDLE, HMP_START, HMP_WAIT, HMP_PROC} hmp_state_t;
endpackage

// ===== rtl/hmp_mode_power_control.sv
// mode, power state, process firing, watchdog and fault latch of the driver
`timescale 1ns/1ps

module hmp_mode_power_control import hmp_pkg::*; #(
	parameter int WDT_CYCLES = HMP_WDT_CYCLES,
	parameter int RECHECK_CYCLES = HMP_RECHECK_CYCLES
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	// register access from the bus slave
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	// bus watchdog
	input wire logic i_bus_open,
	input wire logic i_bus_activity,
	output logic o_bus_idle_reset,
	// pins and analog monitors
	input wire logic i_enable_pin,
	input wire logic i_trigger_input_pin,
	input wire logic i_over_temp,
	input wire logic i_output_short,
	input wire logic i_reg_short,
	input wire logic i_brownout,
	input wire logic [7:0] i_supply_sample,
	// playback engine
	input wire logic i_wave_done,
	input wire logic i_proc_done,
	output logic o_fire,
	output logic o_wave_start,
	output logic [7:0] o_wave_id,
	output logic o_proc_run,
	output logic o_drive_enable,
	// power state
	output logic o_standby,
	output logic o_shutdown,
	output logic [2:0] o_mode,
	output logic o_pwm_select
);
	// ****************
	// state
	// ****************
	logic [7:0] mode_power_control;
	logic [7:0] seq_reg [HMP_SEQ_DEPTH];
	logic go;
	logic over_temp_flag;
	logic output_short_flag;
	logic short_seen;
	logic soft_reset_pending;
	logic restart_pending;
	logic [7:0] supply_level;
	logic trig_prev;
	logic [HMP_CNT_W-1:0] wdt_cnt;
	logic [HMP_CNT_W-1:0] recheck_cnt;
	logic [3:0] seq_idx;
	hmp_state_t state;
	hmp_state_t next_state;

	// ****************
	// decode
	// ****************
	// power-on and fault resets cover everything; the short restart covers all but the short memory
	wire hard_rst = i_sys_rst | i_brownout | i_reg_short;
	wire int_rst = hard_rst | soft_reset_pending | restart_pending;
	wire acc_ok = i_enable_pin;
	wire wr = i_reg_wr & acc_ok;
	wire rd = i_reg_rd & acc_ok;
	wire wr_mode = wr & (i_reg_addr == HMP_ADDR_MODE_POWER);
	wire wr_go = wr & (i_reg_addr == HMP_ADDR_FIRE_CONTROL);
	wire rd_status = rd & (i_reg_addr == HMP_ADDR_FAULT_STATUS);
	wire [2:0] mode = mode_power_control[2:0];
	wire standby = mode_power_control[HMP_BIT_STANDBY];
	wire mode_edge = (mode == HMP_MODE_EDGE);
	wire mode_level = (mode == HMP_MODE_LEVEL);
	wire mode_proc = (mode == HMP_MODE_DIAG) | (mode == HMP_MODE_CALIB);
	wire mode_cont = (mode == HMP_MODE_ANALOG_PWM) |
		(mode == HMP_MODE_AUDIO_VIBE) | (mode == HMP_MODE_REALTIME);
	// drive is gated off by any power-down or fault condition
	wire fault = i_over_temp | output_short_flag | short_seen;
	wire gate_ok = i_enable_pin & ~standby & ~fault;
	wire fire_now = (go | mode_cont) & gate_ok;
	wire running = (state != HMP_IDLE) | (mode_cont & gate_ok);
	wire trig_rise = i_trigger_input_pin & ~trig_prev;
	wire [2:0] seq_sel = seq_idx[2:0];
	wire seq_end = seq_idx[3] | (seq_reg[seq_sel] == HMP_RST_SEQ);
	// an empty first slot ends the run at once, so go must drop there too
	wire seq_finish = ((state == HMP_WAIT) & i_wave_done |
		(state == HMP_START)) & seq_end;
	wire proc_finish = (state == HMP_PROC) & i_proc_done;
	wire wdt_on = ~standby & i_enable_pin & i_bus_open;
	wire wdt_expire = wdt_on & (wdt_cnt == HMP_CNT_W'(WDT_CYCLES - 1));
	wire recheck_tick = (recheck_cnt == HMP_CNT_W'(RECHECK_CYCLES - 1));

	// ****************
	// go bit
	// ****************
	logic next_go;
	always_comb begin
		next_go = go;
		if (mode_level) begin
			next_go = i_trigger_input_pin;
		end else begin
			if (mode_edge & trig_rise) begin
				next_go = ~go;
			end
			if (seq_finish | proc_finish) begin
				next_go = 1'b0;
			end
			if (wr_go) begin
				next_go = i_reg_wdata[HMP_BIT_GO];
			end
		end
		if (standby | ~i_enable_pin) begin
			next_go = 1'b0;
		end
	end

	// ****************
	// process sequencer
	// ****************
	always_comb begin
		next_state = state;
		case (state)
			HMP_IDLE: begin
				if (go & gate_ok & ~mode_cont) begin
					next_state = mode_proc ? HMP_PROC : HMP_START;
				end
			end
			HMP_START: begin
				next_state = seq_end ? HMP_IDLE : HMP_WAIT;
			end
			HMP_WAIT: begin
				if (i_wave_done) begin
					next_state = seq_end ? HMP_IDLE : HMP_START;
				end
			end
			HMP_PROC: begin
				if (i_proc_done) begin
					next_state = HMP_IDLE;
				end
			end
			default: begin
				next_state = HMP_IDLE;
			end
		endcase
		if (~go | ~gate_ok) begin
			next_state = HMP_IDLE;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (int_rst) begin
			state <= HMP_IDLE;
			seq_idx <= 4'h0;
			o_wave_start <= 1'b0;
			o_wave_id <= HMP_RST_SEQ;
		end else begin
			state <= next_state;
			o_wave_start <= 1'b0;
			if (next_state == HMP_IDLE) begin
				seq_idx <= 4'h0;
			end else if (state == HMP_START && next_state == HMP_WAIT) begin
				o_wave_start <= 1'b1;
				o_wave_id <= seq_reg[seq_sel];
				seq_idx <= seq_idx + 4'h1;
			end
		end
	end

	// ****************
	// registers
	// ****************
	// the pending bit never reads back set: the reset it starts also clears the read data
	always_ff @(posedge i_sys_clk) begin
		if (int_rst) begin
			mode_power_control <= HMP_RST_MODE_POWER;
			go <= 1'b0;
			soft_reset_pending <= 1'b0;
			over_temp_flag <= 1'b0;
			supply_level <= HMP_RST_SUPPLY;
			trig_prev <= 1'b0;
		end else begin
			go <= next_go;
			trig_prev <= i_trigger_input_pin;
			if (wr_mode) begin
				mode_power_control <= {1'b0, i_reg_wdata[6:0]};
				soft_reset_pending <= i_reg_wdata[HMP_BIT_SOFT_RESET];
			end
			// set wins over the clear-on-read of the status register
			if (i_over_temp) begin
				over_temp_flag <= 1'b1;
			end else if (rd_status) begin
				over_temp_flag <= 1'b0;
			end
			if (running & i_enable_pin) begin
				supply_level <= i_supply_sample;
			end
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < HMP_SEQ_DEPTH; gi++) begin : g_seq
			always_ff @(posedge i_sys_clk) begin
				if (int_rst) begin
					seq_reg[gi] <= HMP_RST_SEQ;
				end else if (wr && i_reg_addr == HMP_ADDR_SEQ_FIRST + 8'(gi)) begin
					seq_reg[gi] <= i_reg_wdata;
				end
			end
		end
	endgenerate

	// ****************
	// output short handling
	// ****************
	// a new short is only latched while something drives the output
	always_ff @(posedge i_sys_clk) begin
		if (int_rst) begin
			output_short_flag <= 1'b0;
			recheck_cnt <= '0;
			restart_pending <= 1'b0;
		end else begin
			restart_pending <= 1'b0;
			if (~output_short_flag) begin
				recheck_cnt <= '0;
				if (running & i_output_short) begin
					output_short_flag <= 1'b1;
				end
			end else if (recheck_tick) begin
				recheck_cnt <= '0;
				restart_pending <= ~i_output_short;
			end else begin
				recheck_cnt <= recheck_cnt + HMP_CNT_W'(1);
			end
		end
	end

	// survives the short restart so playback stays blocked until mode rewrite
	always_ff @(posedge i_sys_clk) begin
		if (hard_rst | soft_reset_pending) begin
			short_seen <= 1'b0;
		end else if (output_short_flag) begin
			short_seen <= 1'b1;
		end else if (wr_mode) begin
			short_seen <= 1'b0;
		end
	end

	// ****************
	// bus watchdog
	// ****************
	// standby keeps the counter cleared: a stall there needs a power cycle
	always_ff @(posedge i_sys_clk) begin
		if (int_rst) begin
			wdt_cnt <= '0;
			o_bus_idle_reset <= 1'b0;
		end else begin
			o_bus_idle_reset <= wdt_expire;
			if (~wdt_on | i_bus_activity | wdt_expire) begin
				wdt_cnt <= '0;
			end else begin
				wdt_cnt <= wdt_cnt + HMP_CNT_W'(1);
			end
		end
	end

	// ****************
	// read data and outputs
	// ****************
	logic [7:0] next_rdata;
	always_comb begin
		next_rdata = 8'h00;
		if (rd) begin
			case (i_reg_addr)
				HMP_ADDR_FAULT_STATUS: begin
					next_rdata[HMP_BIT_OVER_TEMP] = over_temp_flag;
					next_rdata[HMP_BIT_SHORT_FLAG] = output_short_flag;
				end
				HMP_ADDR_MODE_POWER: begin
					next_rdata = mode_power_control;
					next_rdata[HMP_BIT_SOFT_RESET] = soft_reset_pending;
				end
				HMP_ADDR_FIRE_CONTROL: begin
					next_rdata[HMP_BIT_GO] = go;
				end
				HMP_ADDR_SUPPLY_LEVEL: begin
					next_rdata = supply_level;
				end
				default: begin
					if (i_reg_addr >= HMP_ADDR_SEQ_FIRST &&
						i_reg_addr <= HMP_ADDR_SEQ_LAST) begin
						next_rdata = seq_reg[i_reg_addr[2:0] - 3'h4];
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (int_rst) begin
			o_reg_rdata <= 8'h00;
			o_fire <= 1'b0;
			o_proc_run <= 1'b0;
			o_drive_enable <= 1'b0;
			o_standby <= 1'b1;
			o_shutdown <= 1'b0;
			o_mode <= HMP_MODE_INTERNAL;
			o_pwm_select <= 1'b0;
		end else begin
			o_reg_rdata <= next_rdata;
			o_fire <= fire_now;
			o_proc_run <= (next_state == HMP_PROC);
			o_drive_enable <= running & gate_ok;
			o_standby <= standby;
			o_shutdown <= ~i_enable_pin;
			o_mode <= mode;
			o_pwm_select <= mode_power_control[HMP_BIT_PWM_SELECT];
		end
	end
endmodule

// ===== tb/hmp_asserts.sv
// port assertions for the mode and power control block
`timescale 1ns/1ps
module hmp_asserts import hmp_pkg::*; #(
	parameter int WDT_CYCLES = HMP_WDT_CYCLES
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	// register port
	input wire logic i_reg_rd,
	input wire logic i_enable_pin,
	input wire logic [7:0] o_reg_rdata,
	// bus watchdog
	input wire logic i_bus_open,
	input wire logic i_bus_activity,
	input wire logic o_bus_idle_reset,
	// faults and power state
	input wire logic i_over_temp,
	input wire logic i_brownout,
	input wire logic o_fire,
	input wire logic o_drive_enable,
	input wire logic o_standby,
	input wire logic o_shutdown,
	input wire logic [2:0] o_mode
);
	// ****************
	// checks
	// ****************
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);
	// quiet open cycles; held while asleep so standby cannot fake a stall
	int wc;
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst || i_brownout || !i_bus_open || i_bus_activity
			|| o_bus_idle_reset)
			wc <= 0;
		else if (i_enable_pin && !o_standby)
			wc <= wc + 1;
	end
	sequence asleep_s;
		o_standby [*2];
	endsequence
	a_read_refused: assert property (
		$past(i_reg_rd && !i_enable_pin) |-> o_reg_rdata == 8'h00)
		else $error("read served while disabled");
	a_wdt_early: assert property (
		o_bus_idle_reset |-> wc >= WDT_CYCLES - 2)
		else $error("watchdog fired early");
	a_wdt_late: assert property (wc <= WDT_CYCLES + 2)
		else $error("watchdog missed stall");
	a_wdt_asleep: assert property (asleep_s |-> !o_bus_idle_reset)
		else $error("watchdog fired in standby");
	a_fire_standby: assert property (o_standby [*3] |-> !o_fire)
		else $error("fire in standby");
	a_fire_shutdown: assert property (o_shutdown [*3] |-> !o_fire)
		else $error("fire in shutdown");
	a_shutdown_pin: assert property (
		$past(!i_sys_rst && !i_brownout) |-> o_shutdown == !$past(i_enable_pin))
		else $error("shutdown does not follow enable");
	a_brownout_dflt: assert property (
		$past(i_brownout) |-> o_standby && o_mode == 3'h0)
		else $error("brownout left state");
	a_temp_drive: assert property (i_over_temp [*2] |-> !o_drive_enable)
		else $error("drive on while hot");
endmodule
bind hmp_mode_power_control hmp_asserts #(.WDT_CYCLES(WDT_CYCLES)) chk_u (
	.i_sys_clk, .i_sys_rst, .i_reg_rd, .i_enable_pin, .o_reg_rdata,
	.i_bus_open, .i_bus_activity, .o_bus_idle_reset, .i_over_temp,
	.i_brownout, .o_fire, .o_drive_enable, .o_standby, .o_shutdown, .o_mode
);

// ===== tb/hmp_engine_model.sv
// playback engine model: ends each waveform or process after a delay
`timescale 1ns/1ps
module hmp_engine_model (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	// requests and pace
	input wire logic i_wave_start,
	input wire logic i_proc_run,
	input wire logic [3:0] i_delay,
	// completions
	output logic o_wave_done,
	output logic o_proc_done
);
	// ****************
	// engine
	// ****************
	logic [4:0] w_cnt;
	logic [4:0] p_cnt;
	logic w_busy;
	always_ff @(posedge i_sys_clk) begin
		o_wave_done <= 1'h0;
		if (i_sys_rst || i_wave_start) begin
			w_busy <= i_wave_start;
			w_cnt <= 5'h00;
		end else if (w_busy) begin
			w_cnt <= w_cnt + 5'h01;
			o_wave_done <= w_cnt == {1'h0, i_delay};
			w_busy <= w_cnt != {1'h0, i_delay};
		end
	end
	// saturates so a stuck run never gets a second completion
	always_ff @(posedge i_sys_clk) begin
		if (!i_proc_run)
			p_cnt <= 5'h00;
		else if (p_cnt != 5'h1f)
			p_cnt <= p_cnt + 5'h01;
		o_proc_done <= i_proc_run && p_cnt == {1'h0, i_delay};
	end
endmodule

// ===== tb/hmp_mode_power_control_test.sv
// self-checking bench of the mode and power control block
`timescale 1ns/1ps
module hmp_mode_power_control_test import hmp_pkg::*; ;
	// ****************
	// bench
	// ****************
	logic i_sys_clk, i_sys_rst = 1'h1, i_reg_wr = 1'h0, i_reg_rd = 1'h0;
	logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00;
	logic [7:0] i_supply_sample = 8'h00, o_reg_rdata, o_wave_id, rv;
	logic i_bus_open = 1'h0, i_bus_activity = 1'h0, i_enable_pin = 1'h1;
	logic i_trigger_input_pin = 1'h0, i_over_temp = 1'h0;
	logic i_output_short = 1'h0, i_reg_short = 1'h0, i_brownout = 1'h0;
	logic i_wave_done, i_proc_done, o_bus_idle_reset, o_fire, o_wave_start;
	logic o_proc_run, o_drive_enable, o_standby, o_shutdown, o_pwm_select;
	logic [2:0] o_mode;
	logic [3:0] dly = 4'h0;
	logic [7:0] ids[$];
	int checks = 0, n_mismatch = 0, npulse = 0;
	hmp_mode_power_control #(.WDT_CYCLES(20), .RECHECK_CYCLES(8)) dut_u (
		.i_sys_clk, .i_sys_rst, .i_reg_wr, .i_reg_rd, .i_reg_addr,
		.i_reg_wdata, .o_reg_rdata, .i_bus_open, .i_bus_activity,
		.o_bus_idle_reset, .i_enable_pin, .i_trigger_input_pin, .i_over_temp,
		.i_output_short, .i_reg_short, .i_brownout, .i_supply_sample,
		.i_wave_done, .i_proc_done, .o_fire, .o_wave_start, .o_wave_id,
		.o_proc_run, .o_drive_enable, .o_standby, .o_shutdown, .o_mode,
		.o_pwm_select
	);
	hmp_engine_model eng_u (
		.i_sys_clk, .i_sys_rst, .i_wave_start(o_wave_start),
		.i_proc_run(o_proc_run), .i_delay(dly),
		.o_wave_done(i_wave_done), .o_proc_done(i_proc_done)
	);
	initial begin
		i_sys_clk = 1'h0;
		forever #25 i_sys_clk = ~i_sys_clk;
	end
	always @(posedge i_sys_clk) begin
		if (o_wave_start === 1'h1)
			ids.push_back(o_wave_id);
		if (o_bus_idle_reset === 1'h1)
			npulse++;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask
	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		tick(1);
		i_reg_wr = 1'h1;
		i_reg_addr = a;
		i_reg_wdata = d;
		tick(1);
		i_reg_wr = 1'h0;
	endtask
	task automatic rd(input logic [7:0] a);
		tick(1);
		i_reg_rd = 1'h1;
		i_reg_addr = a;
		tick(1);
		i_reg_rd = 1'h0;
		rv = o_reg_rdata;
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		rd(a);
		chk("rdata", e, rv);
	endtask
	task automatic play(input int n);
		ids.delete();
		wr(8'h0c, 8'h01);
		rd(8'h0c);
		repeat (300) if (rv[0] !== 1'h0) rd(8'h0c);
		chk("go", 8'h00, rv);
		chk("waves", 8'(n), 8'(ids.size()));
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// the whole sequence needs a few hundred cycles
	initial begin
		#1000000;
		n_mismatch++;
		conclude();
	end
	initial begin
		logic [7:0] v;
		int n;
		tick(4);
		i_sys_rst = 1'h0;
		rc(8'h01, 8'h40);
		rc(8'h21, 8'h00);
		rc(8'h02, 8'h00);
		i_enable_pin = 1'h0;
		wr(8'h01, 8'h00);
		chk("shutdown", 8'h01, o_shutdown);
		rc(8'h01, 8'h00);
		i_enable_pin = 1'h1;
		rc(8'h01, 8'h40);
		for (int m = 0; m < 8; m++) begin
			v = {4'h0, m == 3, 3'(m)};
			wr(8'h01, v);
			tick(3);
			rc(8'h01, v);
			chk("mode", 8'(m), o_mode);
			chk("pwm", m == 3, o_pwm_select);
			chk("fire", m inside {3, 4, 5}, o_fire);
			rc(8'h0c, 8'h00);
		end
		wr(8'h01, 8'h05);
		i_over_temp = 1'h1;
		tick(3);
		chk("drive", 8'h00, o_drive_enable);
		chk("fire", 8'h00, o_fire);
		rc(8'h00, 8'h02);
		i_over_temp = 1'h0;
		rc(8'h00, 8'h02);
		rc(8'h00, 8'h00);
		wr(8'h01, 8'h45);
		tick(3);
		chk("fire", 8'h00, o_fire);
		wr(8'h01, 8'h05);
		tick(3);
		wr(8'h01, 8'h80);
		tick(3);
		chk("fire", 8'h00, o_fire);
		rc(8'h01, 8'h40);
		wr(8'h01, 8'h00);
		for (int i = 4; i < 12; i++)
			wr(8'(i), 8'(i + 12));
		i_supply_sample = 8'h9a;
		play(8);
		rc(8'h21, 8'h9a);
		dly = 4'h9;
		wr(8'h06, 8'h00);
		play(2);
		chk("id", 8'h11, ids[1]);
		wr(8'h04, 8'h00);
		play(0);
		wr(8'h04, 8'h10);
		dly = 4'hf;
		ids.delete();
		wr(8'h0c, 8'h01);
		tick(4);
		wr(8'h0c, 8'h00);
		tick(60);
		chk("waves", 8'h01, 8'(ids.size()));
		for (int m = 1; m < 3; m++) begin
			wr(8'h01, 8'(m));
			i_trigger_input_pin = 1'h1;
			tick(2);
			i_trigger_input_pin = 1'(m == 2);
			tick(2);
			rc(8'h0c, 8'h01);
			i_trigger_input_pin = 1'h1;
			tick(2);
			i_trigger_input_pin = 1'h0;
			tick(2);
			rc(8'h0c, 8'h00);
		end
		for (int m = 6; m < 8; m++) begin
			wr(8'h01, 8'(m));
			wr(8'h0c, 8'h01);
			tick(2);
			chk("proc", 8'h01, o_proc_run);
			play(0);
			chk("proc", 8'h00, o_proc_run);
		end
		wr(8'h01, 8'h00);
		i_output_short = 1'h1;
		tick(4);
		rc(8'h00, 8'h00);
		wr(8'h0c, 8'h01);
		tick(4);
		rc(8'h00, 8'h01);
		chk("drive", 8'h00, o_drive_enable);
		i_output_short = 1'h0;
		tick(30);
		rc(8'h01, 8'h40);
		wr(8'h01, 8'h00);
		wr(8'h04, 8'h21);
		play(1);
		i_bus_open = 1'h1;
		i_bus_activity = 1'h1;
		tick(1);
		i_bus_activity = 1'h0;
		n = 0;
		while (o_bus_idle_reset !== 1'h1 && n < 40) begin
			tick(1);
			n++;
		end
		chk("wdt", 8'h01, n >= 19 && n <= 21);
		i_bus_open = 1'h0;
		wr(8'h01, 8'h40);
		i_bus_open = 1'h1;
		npulse = 0;
		tick(50);
		chk("wdt", 8'h00, 8'(npulse));
		i_bus_open = 1'h0;
		for (int k = 0; k < 2; k++) begin
			wr(8'h01, 8'h05);
			i_brownout = 1'(k == 0);
			i_reg_short = 1'(k == 1);
			tick(2);
			i_brownout = 1'h0;
			i_reg_short = 1'h0;
			rc(8'h01, 8'h40);
		end
		conclude();
	end
endmodule
